// *** pkg/dac_seq_pkg.sv ***
// Shared constants, encodings and state types for the converter sequencer
package dac_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_PERIOD_US = 100;
  localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam logic [9:0]  TICK_LAST      = 10'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_IRQ_CTRL  = 12'h0B0;
  localparam logic [11:0] ADDR_CTRL      = 12'h0C0;
  localparam logic [11:0] ADDR_STATUS    = 12'h0C4;
  localparam logic [11:0] ADDR_PRELOAD   = 12'h0C8;
  localparam logic [11:0] ADDR_CHAN_BASE = 12'h0D0;
  localparam logic [11:0] ADDR_CHAN_LAST = 12'h0EC;
  localparam logic [11:0] ADDR_LINE_DIR  = 12'h100;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RESET_BIT    = 0;
  localparam int unsigned CTRL_RESET_SEL    = 1;
  localparam int unsigned CTRL_LOAD_BIT     = 2;
  localparam int unsigned CTRL_MODE_LSB     = 3;
  localparam int unsigned CTRL_IRQ_EN_BIT   = 5;
  localparam int unsigned STAT_REQ_BIT      = 0;
  localparam int unsigned STAT_UNDER_BIT    = 1;
  localparam int unsigned STAT_PEND_BIT     = 2;
  localparam int unsigned IRQC_MASTER_BIT   = 0;
  localparam int unsigned LINE_TRIG_OUT_BIT = 17;
  localparam int unsigned LINE_TRIG_PIN     = 1;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 8;
  localparam logic [15:0] MIDSCALE = 16'h0000;

  typedef enum logic [1:0] {
    MODE_IMMEDIATE = 2'h0,
    MODE_MANUAL    = 2'h1,
    MODE_TIMER     = 2'h2,
    MODE_TRIGGER   = 2'h3
  } load_mode_t;

  typedef enum logic [3:0] {
    BUS_IDLE    = 4'h1,
    BUS_WRITE   = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DATA = 4'h8
  } bus_state_t;

  typedef struct packed {
    bus_state_t        bus;
    logic [11:0]       ph_addr;
    logic [31:0]       rdata;
    load_mode_t        load_mode;
    logic              reset_sel;
    logic              irq_en;
    logic              master_irq_en;
    logic [15:0]       line_dir;
    logic              trig_out_en;
    logic [15:0]       preload;
    logic              data_req;
    logic              underflow;
    logic [1:0]        sync_loc;
    logic [1:0]        sync_trig;
    logic              trig_prev;
    logic              trig_pulse;
    logic [7:0][15:0]  staged;
    logic [7:0][15:0]  dac;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{bus: BUS_IDLE, load_mode: MODE_IMMEDIATE, underflow: 1'b1, default: '0};

  typedef struct packed {
    logic        running;
    logic [15:0] count;
  } timer_state_t;

  typedef struct packed {
    logic [9:0] count;
    logic       tick;
  } div_state_t;

endpackage

// *** design/tick_divider.sv ***
// Prescaler producing the 100 us sequencer tick enable
`timescale 1ns/1ps
module tick_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  input  wire logic run,
  // Tick enable
  output logic      tick
);

  dac_seq_pkg::div_state_t d;
  dac_seq_pkg::div_state_t next_d;

  always_comb begin
    next_d      = d;
    next_d.tick = 1'b0;
    if (!run) begin
      next_d.count = '0;
    end else if (d.count == dac_seq_pkg::TICK_LAST) begin
      next_d.count = '0;
      next_d.tick  = 1'b1;
    end else begin
      next_d.count = d.count + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign tick = d.tick;

endmodule

// *** design/seq_timer.sv ***
// Sequencer down-counter, reloaded from the preload value each sequence
`timescale 1ns/1ps
module seq_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [15:0] preload,
  // Sequence start pulse
  output logic             expire
);

  dac_seq_pkg::timer_state_t t;
  dac_seq_pkg::timer_state_t next_t;

  always_comb begin
    next_t = t;
    expire = 1'b0;
    if (!run || preload == 16'h0000) begin
      next_t.running = 1'b0;
    end else if (!t.running) begin
      next_t.running = 1'b1;
      next_t.count   = preload;
    end else if (tick) begin
      if (t.count <= 16'h0001) begin
        expire       = 1'b1;
        next_t.count = preload;
      end else begin
        next_t.count = t.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_zero_no_start: assert property (preload == 16'h0000 |-> !expire) else $error("timer fired with zero preload");
  a_expire_on_tick: assert property (expire |-> tick && t.running) else $error("timer fired off tick");

endmodule

// *** design/dac_seq_ctrl.sv ***
// Eight-channel converter control with load modes, sequencer and AHB-Lite registers
// Notes on behaviour
// - Manual load bit write copies all staged values to outputs; bit reads zero
// - Reset command bit drives all outputs to midscale, self-clears
// - Reset command also sets staged data registers to midscale
// - Outputs held at reset while bus or local reset is active
// - Interrupt output only while master interrupt enable is set
// - Trigger output enable drives sequence trigger on line 1, overriding direction
// - Status bit 2 shows pending interrupt; cleared with data request flag
// - Underflow bit 1 set when sequence ready without new data; resets to one
// - Data request bit 0 set when sequencer needs fresh data
// - Software clears data request by writing one after loading data
// - Selecting timer mode starts the sequencer timer
// - Timer does not start with zero preload
// - Timer reloads preload each sequence; period is preload ticks of 100 us
// - The 100 us tick is derived from the board clock
// - Eight channel registers at consecutive words; immediate mode writes output at once
// - Channel registers hold midscale after reset
// - Codes are two's complement, 0x0000 midscale
// - Timer mode updates all outputs when the timer reaches zero
// - Trigger mode updates all outputs on a line 1 trigger
// - Data request in timer or trigger mode raises interrupt when enabled
// - Buffered modes hold written data until update; unwritten channels reuse old
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module dac_seq_ctrl (
  // Clock and resets
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        LOCAL_RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Converter outputs
  output logic [7:0][15:0] DAC_CODE,
  output logic             DAC_HOLD,
  output logic             IRQ,
  // Digital line 1
  input  wire logic        LINE1_IN,
  output logic             LINE1_OUT,
  output logic             LINE1_OE
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic chan_hit(input logic [11:0] addr);
    chan_hit = addr >= dac_seq_pkg::ADDR_CHAN_BASE && addr <= dac_seq_pkg::ADDR_CHAN_LAST && addr[1:0] == 2'h0;
  endfunction

  function automatic logic [2:0] chan_index(input logic [11:0] addr);
    logic [11:0] off;
    off        = addr - dac_seq_pkg::ADDR_CHAN_BASE;
    chan_index = off[4:2];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dac_seq_pkg::ctrl_state_t s;
  dac_seq_pkg::ctrl_state_t next_s;
  logic                     take;
  logic                     wr_now;
  logic                     update;
  logic                     sw_clear;
  logic                     reset_cmd;
  logic                     pending;
  logic                     run_timer;
  logic                     tick;
  logic                     timer_expire;
  logic                     trig_edge;
  logic [31:0]              rd_word;
  logic [2:0]               idx;

  assign take      = HSEL && HTRANS[1] && HREADY;
  assign wr_now    = s.bus == dac_seq_pkg::BUS_WRITE;
  assign idx       = chan_index(s.ph_addr);
  assign trig_edge = s.sync_trig[1] && !s.trig_prev;
  // Only the timer and trigger modes raise interrupt requests toward the host
  assign pending   = s.data_req && s.irq_en && s.load_mode[1];
  assign run_timer = s.load_mode == dac_seq_pkg::MODE_TIMER && s.sync_loc[1];

  // ----------------------------------------------------------------
  // Tick and timer
  // ----------------------------------------------------------------
  tick_divider u_div (
    .clk  (CLK),
    .nrst (NRST),
    .run  (run_timer),
    .tick (tick)
  );

  seq_timer u_timer (
    .clk     (CLK),
    .nrst    (NRST),
    .run     (run_timer),
    .tick    (tick),
    .preload (s.preload),
    .expire  (timer_expire)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (chan_hit(s.ph_addr)) begin
      rd_word[15:0] = s.staged[chan_index(s.ph_addr)];
    end else begin
      case (s.ph_addr)
        dac_seq_pkg::ADDR_CTRL: begin
          // Command bits are strobes and always read back as zero
          rd_word[dac_seq_pkg::CTRL_IRQ_EN_BIT] = s.irq_en;
          rd_word[dac_seq_pkg::CTRL_MODE_LSB+:2] = s.load_mode;
          rd_word[dac_seq_pkg::CTRL_RESET_SEL] = s.reset_sel;
        end
        dac_seq_pkg::ADDR_STATUS: begin
          rd_word[dac_seq_pkg::STAT_PEND_BIT]  = pending;
          rd_word[dac_seq_pkg::STAT_UNDER_BIT] = s.underflow;
          rd_word[dac_seq_pkg::STAT_REQ_BIT]   = s.data_req;
        end
        dac_seq_pkg::ADDR_PRELOAD: begin
          rd_word[15:0] = s.preload;
        end
        dac_seq_pkg::ADDR_IRQ_CTRL: begin
          rd_word[dac_seq_pkg::IRQC_MASTER_BIT] = s.master_irq_en;
        end
        dac_seq_pkg::ADDR_LINE_DIR: begin
          rd_word[15:0] = s.line_dir;
          rd_word[dac_seq_pkg::LINE_TRIG_OUT_BIT] = s.trig_out_en;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s            = s;
    update            = 1'b0;
    sw_clear          = 1'b0;
    reset_cmd         = 1'b0;
    next_s.trig_pulse = 1'b0;
    next_s.sync_loc   = {s.sync_loc[0], LOCAL_RST_N};
    next_s.sync_trig  = {s.sync_trig[0], LINE1_IN};
    next_s.trig_prev  = s.sync_trig[1];

    case (s.bus)
      dac_seq_pkg::BUS_RD_WAIT: begin
        next_s.rdata = rd_word;
        next_s.bus   = dac_seq_pkg::BUS_RD_DATA;
      end
      dac_seq_pkg::BUS_IDLE, dac_seq_pkg::BUS_WRITE, dac_seq_pkg::BUS_RD_DATA: begin
        if (take) begin
          next_s.ph_addr = HADDR[11:0];
          next_s.bus     = HWRITE ? dac_seq_pkg::BUS_WRITE : dac_seq_pkg::BUS_RD_WAIT;
        end else begin
          next_s.bus = dac_seq_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_s.bus = dac_seq_pkg::BUS_IDLE;
      end
    endcase

    if (wr_now) begin
      if (chan_hit(s.ph_addr)) begin
        next_s.staged[idx] = HWDATA[15:0];
        if (s.load_mode == dac_seq_pkg::MODE_IMMEDIATE) begin
          next_s.dac[idx] = HWDATA[15:0];
        end
      end else begin
        case (s.ph_addr)
          dac_seq_pkg::ADDR_CTRL: begin
            next_s.load_mode = dac_seq_pkg::load_mode_t'(HWDATA[dac_seq_pkg::CTRL_MODE_LSB+:2]);
            next_s.reset_sel = HWDATA[dac_seq_pkg::CTRL_RESET_SEL];
            next_s.irq_en    = HWDATA[dac_seq_pkg::CTRL_IRQ_EN_BIT];
            reset_cmd        = HWDATA[dac_seq_pkg::CTRL_RESET_BIT];
            if (HWDATA[dac_seq_pkg::CTRL_LOAD_BIT] &&
                HWDATA[dac_seq_pkg::CTRL_MODE_LSB+:2] == dac_seq_pkg::MODE_MANUAL) begin
              update = 1'b1;
            end
          end
          dac_seq_pkg::ADDR_STATUS: begin
            sw_clear = HWDATA[dac_seq_pkg::STAT_REQ_BIT];
          end
          dac_seq_pkg::ADDR_PRELOAD: begin
            next_s.preload = HWDATA[15:0];
          end
          dac_seq_pkg::ADDR_IRQ_CTRL: begin
            next_s.master_irq_en = HWDATA[dac_seq_pkg::IRQC_MASTER_BIT];
          end
          dac_seq_pkg::ADDR_LINE_DIR: begin
            next_s.line_dir    = HWDATA[15:0];
            next_s.trig_out_en = HWDATA[dac_seq_pkg::LINE_TRIG_OUT_BIT];
          end
          default: begin
            next_s.preload = s.preload;
          end
        endcase
      end
    end

    if (s.load_mode == dac_seq_pkg::MODE_TIMER && timer_expire) begin
      update = 1'b1;
    end
    // Looping the trigger output back into trigger mode retriggers itself every three cycles here
    if (s.load_mode == dac_seq_pkg::MODE_TRIGGER && trig_edge) begin
      update = 1'b1;
    end

    if (sw_clear) begin
      next_s.data_req  = 1'b0;
      next_s.underflow = 1'b0;
    end
    // A sequence start in the clearing cycle still raises the request
    if (update) begin
      next_s.dac        = s.staged;
      next_s.data_req   = 1'b1;
      next_s.underflow  = 1'b1;
      next_s.trig_pulse = 1'b1;
    end
    if (reset_cmd) begin
      for (int i = 0; i < dac_seq_pkg::NUM_CHAN; i++) begin
        next_s.staged[i] = dac_seq_pkg::MIDSCALE;
        next_s.dac[i]    = dac_seq_pkg::MIDSCALE;
      end
    end
    if (!s.sync_loc[1]) begin
      for (int i = 0; i < dac_seq_pkg::NUM_CHAN; i++) begin
        next_s.dac[i] = dac_seq_pkg::MIDSCALE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s <= dac_seq_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HREADYOUT = s.bus != dac_seq_pkg::BUS_RD_WAIT;
  assign HRESP     = 1'b0;
  assign HRDATA    = s.rdata;
  assign DAC_CODE  = s.dac;
  assign DAC_HOLD  = !s.sync_loc[1];
  assign IRQ       = pending && s.master_irq_en;
  assign LINE1_OE  = s.trig_out_en || s.line_dir[dac_seq_pkg::LINE_TRIG_PIN];
  // No line output data register here; an output-direction line drives low
  assign LINE1_OUT = s.trig_out_en && s.trig_pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_manual_load: assert property (wr_now && s.ph_addr == dac_seq_pkg::ADDR_CTRL
      && HWDATA[dac_seq_pkg::CTRL_LOAD_BIT] && !HWDATA[dac_seq_pkg::CTRL_RESET_BIT]
      && HWDATA[4:3] == 2'h1 && s.sync_loc[1] |=> s.dac == $past(s.staged))
    else $error("manual load did not copy staged data");

  a_cmd_read_zero: assert property (s.bus == dac_seq_pkg::BUS_RD_WAIT && s.ph_addr == dac_seq_pkg::ADDR_CTRL
      |=> s.rdata[dac_seq_pkg::CTRL_LOAD_BIT] == 1'b0 && s.rdata[dac_seq_pkg::CTRL_RESET_BIT] == 1'b0)
    else $error("command bit read back as one");

  a_reset_midscale: assert property (wr_now && s.ph_addr == dac_seq_pkg::ADDR_CTRL
      && HWDATA[dac_seq_pkg::CTRL_RESET_BIT] |=> s.dac == '0 && s.staged == '0)
    else $error("reset command left non-midscale data");

  // Hold flag follows the synced reset at once; the forced codes land one edge later
  a_local_hold: assert property (!s.sync_loc[1] |-> DAC_HOLD ##1 DAC_CODE == '0)
    else $error("outputs not held in local reset");

  a_irq_gated: assert property (IRQ |-> s.master_irq_en && s.data_req && s.load_mode[1])
    else $error("interrupt raised without enables");

  a_trig_line: assert property (s.trig_out_en |-> LINE1_OE && LINE1_OUT == s.trig_pulse)
    else $error("trigger not driven on line 1");

  a_update_flags: assert property (update && !reset_cmd |=> s.data_req && s.underflow && s.trig_pulse)
    else $error("sequence start did not raise flags");

  a_clear_req: assert property (sw_clear && !update |=> !s.data_req && !s.underflow && !pending)
    else $error("data request not cleared by write");

  a_immediate_wr: assert property (wr_now && chan_hit(s.ph_addr)
      && s.load_mode == dac_seq_pkg::MODE_IMMEDIATE && s.sync_loc[1]
      |=> s.dac[$past(idx)] == $past(HWDATA[15:0]))
    else $error("immediate write did not reach output");

  a_buffer_hold: assert property (s.load_mode != dac_seq_pkg::MODE_IMMEDIATE && !update && !reset_cmd
      && s.sync_loc[1] |=> $stable(s.dac))
    else $error("buffered output changed before update");

  c_manual: cover property (update && s.load_mode == dac_seq_pkg::MODE_MANUAL);
  c_timer: cover property (timer_expire && s.load_mode == dac_seq_pkg::MODE_TIMER);
  c_trigger: cover property (trig_edge && s.load_mode == dac_seq_pkg::MODE_TRIGGER);
  c_irq_ack: cover property (IRQ ##1 sw_clear);

endmodule

// *** dv/host_bus_model.sv ***
// AHB-Lite host master standing in for the driver software
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input  wire logic        clk,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic        rdy_s;
  logic [31:0] rd_s;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
  end

  // Nothing moves between falling and rising edge, so this is what the rising edge sees
  always @(negedge clk) begin
    rdy_s = hready;
    rd_s  = hrdata;
  end

  // ----------------------------------------------------------------
  // Single word transfer, entered right after a rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
    rd = rd_s;
  endtask

  // Software acknowledges new data by writing one to the request flag
  task automatic clear_request();
    logic [31:0] v;
    xfer(1'b1, dac_seq_pkg::ADDR_STATUS, 32'h00000001, v);
  endtask
endmodule

// *** dv/multichannel_dac_sequencer_tb_top.sv ***
// Self-checking bench for the converter sequencer register block
`timescale 1ns/1ps
module multichannel_dac_sequencer_tb_top;
  logic             clk;
  logic             nrst;
  logic             local_rst_n;
  logic             line1_in;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  logic [7:0][15:0] dac_code;
  logic             dac_hold;
  logic             irq;
  logic             line1_out;
  logic             line1_oe;
  int               err_total;
  int               n_compared;
  int               cycles;
  int               k;

  dac_seq_ctrl dac_seq_ctrl_i (
    .CLK(clk), .NRST(nrst), .LOCAL_RST_N(local_rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .DAC_CODE(dac_code), .DAC_HOLD(dac_hold), .IRQ(irq),
    .LINE1_IN(line1_in), .LINE1_OUT(line1_out), .LINE1_OE(line1_oe)
  );

  host_bus_model host_i (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host_i.xfer(1'b0, a, 32'h00000000, v);
    check(what, exp, v);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    host_i.xfer(1'b1, a, d, v);
  endtask

  // Polls at falling edges so the design's own edge has landed; lim 0 checks at once
  task automatic wait_code(input string what, input int ch, input logic [15:0] v, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (dac_code[ch] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(what, {16'h0000, v}, {16'h0000, dac_code[ch]});
    @(posedge clk);
  endtask

  // Long timer waits dominate; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    local_rst_n = 1'b1;
    line1_in = 1'b0;
    err_total = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rchk("status", dac_seq_pkg::ADDR_STATUS, 32'h00000002);
    check("hresp", 32'h00000000, {31'h00000000, hresp});
    rchk("preload", dac_seq_pkg::ADDR_PRELOAD, 32'h00000000);
    rchk("chan1", dac_seq_pkg::ADDR_CHAN_BASE, 32'h00000000);
    rchk("unmapped", 12'h0F0, 32'h00000000);
    wait_code("out1", 0, 16'h0000, 0);
    wr(dac_seq_pkg::ADDR_CHAN_BASE, 32'h00007FFF);
    wait_code("out1", 0, 16'h7FFF, 0);
    wr(dac_seq_pkg::ADDR_CHAN_LAST, 32'hFFFF8000);
    wait_code("out8", 7, 16'h8000, 0);
    rchk("chan8", dac_seq_pkg::ADDR_CHAN_LAST, 32'h00008000);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000008);
    wr(dac_seq_pkg::ADDR_CHAN_BASE + 12'h004, 32'h00000001);
    wait_code("out2", 1, 16'h0000, 0);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h0000000C);
    wait_code("out2", 1, 16'h0001, 0);
    wait_code("out1", 0, 16'h7FFF, 0);
    rchk("control", dac_seq_pkg::ADDR_CTRL, 32'h00000008);
    rchk("status", dac_seq_pkg::ADDR_STATUS, 32'h00000003);
    host_i.clear_request();
    rchk("status", dac_seq_pkg::ADDR_STATUS, 32'h00000000);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000001);
    wait_code("out1", 0, 16'h0000, 0);
    rchk("chan1", dac_seq_pkg::ADDR_CHAN_BASE, 32'h00000000);
    rchk("chan8", dac_seq_pkg::ADDR_CHAN_LAST, 32'h00000000);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000010);
    wr(dac_seq_pkg::ADDR_CHAN_BASE + 12'h00C, 32'h00001234);
    repeat (2500) @(posedge clk);
    wait_code("out4", 3, 16'h0000, 0);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000000);
    wr(dac_seq_pkg::ADDR_PRELOAD, 32'h00000002);
    rchk("preload", dac_seq_pkg::ADDR_PRELOAD, 32'h00000002);
    wr(dac_seq_pkg::ADDR_IRQ_CTRL, 32'h00000001);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000030);
    repeat (1990) @(posedge clk);
    wait_code("out4", 3, 16'h0000, 0);
    wait_code("out4", 3, 16'h1234, 40);
    @(negedge clk);
    check("irq", 32'h00000001, {31'h00000000, irq});
    @(posedge clk);
    rchk("status", dac_seq_pkg::ADDR_STATUS, 32'h00000007);
    wr(dac_seq_pkg::ADDR_IRQ_CTRL, 32'h00000000);
    @(negedge clk);
    check("irq", 32'h00000000, {31'h00000000, irq});
    @(posedge clk);
    wr(dac_seq_pkg::ADDR_IRQ_CTRL, 32'h00000001);
    host_i.clear_request();
    @(negedge clk);
    check("irq", 32'h00000000, {31'h00000000, irq});
    @(posedge clk);
    rchk("status", dac_seq_pkg::ADDR_STATUS, 32'h00000000);
    wr(dac_seq_pkg::ADDR_LINE_DIR, 32'h00020000);
    @(negedge clk);
    check("line1 enable", 32'h00000001, {31'h00000000, line1_oe});
    k = 0;
    while (line1_out !== 1'b1 && k < 2100) begin
      @(negedge clk);
      k++;
    end
    check("line1 pulse", 32'h00000001, {31'h00000000, line1_out});
    @(posedge clk);
    // Trigger output off before trigger mode, or a looped line retriggers the sequencer
    wr(dac_seq_pkg::ADDR_LINE_DIR, 32'h00000000);
    wr(dac_seq_pkg::ADDR_CTRL, 32'h00000018);
    wr(dac_seq_pkg::ADDR_CHAN_BASE + 12'h010, 32'h00008001);
    wait_code("out5", 4, 16'h0000, 0);
    line1_in <= 1'b1;
    wait_code("out5", 4, 16'h8001, 10);
    line1_in <= 1'b0;
    local_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("hold", 32'h00000001, {31'h00000000, dac_hold});
    check("out4", 32'h00000000, {16'h0000, dac_code[3]});
    @(posedge clk);
    local_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("hold", 32'h00000000, {31'h00000000, dac_hold});
    finish_test();
  end
endmodule
